// ==== pkg/mms_pkg.sv ====
// package: opcodes, field positions and reset values for the mode-set decoder
package mms_pkg;
  // instruction opcode patterns (upper bits of the word)
  localparam logic [10:0] MMS_CRB_OPC = 11'h1ba; // 00110111010 in 15:5
  localparam logic [13:0] MMS_CRT_OPC = 14'h0d63; // 00110101100011 in 15:2
  localparam logic [14:0] MMS_DCC_OPC = 15'h1a81; // 001101010000001 in 15:1
  localparam logic [13:0] MMS_DAC_OPC = 14'h0d61; // 00110101100001 in 15:2
  localparam logic [13:0] MMS_DRM_OPC = 14'h0d60; // 00110101100000 in 15:2
  // field positions
  localparam int MMS_CRB_LVL_BIT = 4;
  localparam int MMS_CRB_ZERO_BIT = 3;
  localparam int MMS_CRB_OPC_LSB = 5;
  localparam int MMS_F2_OPC_LSB = 2;
  localparam int MMS_F1_OPC_LSB = 1;
  localparam int MMS_CTRL_UPPER_LSB = 8;
  // instruction word and data byte fields
  localparam int MMS_INSTR_MSB = 15;
  localparam int MMS_SEL_MSB = 2;
  localparam int MMS_OPND_MSB = 1;
  localparam int MMS_OPND_LSB = 0;
  localparam int MMS_CTRL_W = 8;
  localparam int MMS_BYTE_W = 8;
  localparam int MMS_HI_LSB = 8;
  // shared-register targets
  typedef enum logic [1:0] {
    MMS_TGT_SELF = 2'b00,
    MMS_TGT_OTHER_UC = 2'b01,
    MMS_TGT_OTHER_CH = 2'b10,
    MMS_TGT_OTHER_BOTH = 2'b11
  } mms_target_type;
  // dac access modes
  typedef enum logic [1:0] {
    MMS_DAC_BOOST = 2'b00,
    MMS_DAC_VALUE = 2'b01,
    MMS_DAC_OFFSET = 2'b10,
    MMS_DAC_FULL = 2'b11
  } mms_dac_type;
  // data ram read modes
  typedef enum logic [1:0] {
    MMS_RD_WORD = 2'b00,
    MMS_RD_LOW = 2'b01,
    MMS_RD_HIGH = 2'b10,
    MMS_RD_SWAP = 2'b11
  } mms_rdmode_type;
  // reset values
  localparam logic [1:0] MMS_TGT_RST = 2'b00;
  localparam logic MMS_DCC_RST = 1'b0;
  localparam logic [1:0] MMS_DAC_RST = 2'b01;
  localparam logic [1:0] MMS_DRM_RST = 2'b00;
  localparam logic [7:0] MMS_CTRL_RST = 8'h00;
  // dac data field slices
  localparam int MMS_DAC_VAL_W = 8;
  localparam int MMS_OFS_W = 6;
  localparam int MMS_4NEG_W = 4;
  localparam int MMS_DATA_W = 16;
endpackage : mms_pkg

// ==== rtl/mms_mode_set.sv ====
// mode-set instruction decoder and the mode-driven data paths of a microcore
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE1] set one upper control bit to level
// [RULE2] control-bit opcode in 15:5, zero bit 3
// [RULE3] two-bit shared-register target select
// [RULE4] read any core's shared transfer register
// [RULE5] target resets to own shared register
// [RULE6] target-select opcode in 15:2
// [RULE7] converter mode: core or automatic regulation
// [RULE8] converter mode resets to core-controlled
// [RULE9] converter-mode opcode in 15:1
// [RULE10] store two-bit dac slice access mode
// [RULE11] mode 01 returns value in low byte
// [RULE12] mode 10 offset 13:8, 4neg 11:8
// [RULE13] mode 00: dac nothing, combined boost
// [RULE14] mode 11 reaches both slices
// [RULE15] dac mode resets to value mode
// [RULE16] dac-mode opcode in 15:2
// [RULE17] word mode passes all sixteen bits
// [RULE18] byte modes zero-extend selected byte
// [RULE19] swap mode exchanges the two bytes
// [RULE20] read mode applies to later loads
// [RULE21] read mode resets word; opcode 15:2
// [RULE22] other control bits stay unchanged
module mms_mode_set
  import mms_pkg::*;
#(
  parameter int DW = MMS_DATA_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // instruction from the sequencer
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  // shared transfer registers of the four cores
  input wire logic [DW-1:0] xfer_self_i,
  input wire logic [DW-1:0] xfer_other_uc_i,
  input wire logic [DW-1:0] xfer_other_ch_i,
  input wire logic [DW-1:0] xfer_other_both_i,
  // dac register sources
  input wire logic [7:0] dac_value_i,
  input wire logic [5:0] dac_offset_i,
  input wire logic [7:0] dac_4h_i,
  input wire logic [3:0] dac_4neg_i,
  input wire logic [7:0] dac_boost_i,
  input wire logic dac_rd_i,
  input wire logic dac_rd_combined_i,
  // data ram load path
  input wire logic ram_load_i,
  input wire logic [DW-1:0] ram_word_i,
  // control and mode state
  output logic [7:0] ctrl_upper_o,
  output logic [1:0] channel_transfer_sel_o,
  output logic [DW-1:0] channel_transfer_reg_o,
  output logic converter_mode_field_o,
  output logic [1:0] dac_access_field_o,
  output logic [1:0] ram_read_mode_field_o,
  // data results
  output logic [DW-1:0] dac_rd_data_o,
  output logic dac_rd_none_o,
  output logic [DW-1:0] load_data_o,
  output logic load_valid_o
);

  // reset release through two flops
  logic rst_s1_reg;
  logic rst_n_reg;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // opcode match of the five mode words
  wire logic opc_crb;
  wire logic opc_crt;
  wire logic opc_dcc;
  wire logic opc_dac;
  wire logic opc_drm;
  wire logic hit_crb;
  wire logic hit_crt;
  wire logic hit_dcc;
  wire logic hit_dac;
  wire logic hit_drm;
  assign opc_crb = instr_i[MMS_INSTR_MSB:MMS_CRB_OPC_LSB] == MMS_CRB_OPC
    && !instr_i[MMS_CRB_ZERO_BIT]; // [RULE2]
  assign opc_crt =
    instr_i[MMS_INSTR_MSB:MMS_F2_OPC_LSB] == MMS_CRT_OPC; // [RULE6]
  assign opc_dcc =
    instr_i[MMS_INSTR_MSB:MMS_F1_OPC_LSB] == MMS_DCC_OPC; // [RULE9]
  assign opc_dac =
    instr_i[MMS_INSTR_MSB:MMS_F2_OPC_LSB] == MMS_DAC_OPC; // [RULE16]
  assign opc_drm =
    instr_i[MMS_INSTR_MSB:MMS_F2_OPC_LSB] == MMS_DRM_OPC; // [RULE21]

  // a word only counts while the strobe is high
  assign hit_crb = instr_valid_i && opc_crb;
  assign hit_crt = instr_valid_i && opc_crt;
  assign hit_dcc = instr_valid_i && opc_dcc;
  assign hit_dac = instr_valid_i && opc_dac;
  assign hit_drm = instr_valid_i && opc_drm;

  // control bit selector and level
  wire logic [2:0] ctrl_bit_selector;
  wire logic crb_level;
  assign ctrl_bit_selector = instr_i[MMS_SEL_MSB:MMS_OPND_LSB]; // [RULE1]
  assign crb_level = instr_i[MMS_CRB_LVL_BIT]; // [RULE1]

  // operand fields of the two-bit and one-bit mode words
  wire logic [1:0] mode_field;
  wire logic dcc_field;
  assign mode_field = instr_i[MMS_OPND_MSB:MMS_OPND_LSB];
  assign dcc_field = instr_i[MMS_OPND_LSB]; // [RULE7]

  // one-hot form of the bit selector
  wire logic [MMS_CTRL_W-1:0] sel_onehot;
  assign sel_onehot = MMS_CTRL_W'(1) << ctrl_bit_selector; // [RULE1]

  // mode state registers
  logic [MMS_CTRL_W-1:0] ctrl_reg;
  logic [1:0] tgt_reg;
  logic dcc_reg;
  logic [1:0] dacm_reg;
  logic [1:0] drm_reg;

  // next values of the mode state
  wire logic [MMS_CTRL_W-1:0] ctrl_next;
  wire logic [1:0] tgt_next;
  wire logic dcc_next;
  wire logic [1:0] dacm_next;
  wire logic [1:0] drm_next;

  // per-bit control update; unselected bits hold their value
  genvar gi;
  generate
    for (gi = 0; gi < MMS_CTRL_W; gi++) begin : g_ctrl
      assign ctrl_next[gi] = (hit_crb && sel_onehot[gi]) ? crb_level
        : ctrl_reg[gi]; // [RULE1] [RULE22]
    end
  endgenerate

  // other mode words load their operand on a match, else hold
  assign tgt_next = hit_crt ? mode_field : tgt_reg; // [RULE3]
  assign dcc_next = hit_dcc ? dcc_field : dcc_reg; // [RULE7]
  assign dacm_next = hit_dac ? mode_field : dacm_reg; // [RULE10]
  assign drm_next = hit_drm ? mode_field : drm_reg; // [RULE20]

  // control register bits 15:8
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= MMS_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next; // [RULE1] [RULE22]
    end
  end

  // shared-register target, back on the own core after reset
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tgt_reg <= MMS_TGT_RST; // [RULE5]
    end else begin
      tgt_reg <= tgt_next; // [RULE3]
    end
  end

  // converter mode, core-controlled after reset
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dcc_reg <= MMS_DCC_RST; // [RULE8]
    end else begin
      dcc_reg <= dcc_next; // [RULE7]
    end
  end

  // dac access mode, value mode after reset
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dacm_reg <= MMS_DAC_RST; // [RULE15]
    end else begin
      dacm_reg <= dacm_next; // [RULE10]
    end
  end

  // data ram read mode, full word after reset
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      drm_reg <= MMS_DRM_RST; // [RULE21]
    end else begin
      drm_reg <= drm_next; // [RULE20]
    end
  end

  // decode of the stored shared-register target
  wire logic ts_uc;
  wire logic ts_ch;
  wire logic ts_both;
  assign ts_uc = tgt_reg == MMS_TGT_OTHER_UC;
  assign ts_ch = tgt_reg == MMS_TGT_OTHER_CH;
  assign ts_both = tgt_reg == MMS_TGT_OTHER_BOTH;

  // shared transfer register selection
  wire logic [DW-1:0] xfer_next;
  assign xfer_next = ts_both ? xfer_other_both_i
    : ts_ch ? xfer_other_ch_i
    : ts_uc ? xfer_other_uc_i
    : xfer_self_i; // [RULE4]

  // decode of the stored dac access mode
  wire logic dm_boost;
  wire logic dm_value;
  wire logic dm_offset;
  wire logic dm_full;
  assign dm_boost = dacm_reg == MMS_DAC_BOOST;
  assign dm_value = dacm_reg == MMS_DAC_VALUE;
  assign dm_offset = dacm_reg == MMS_DAC_OFFSET;
  assign dm_full = dacm_reg == MMS_DAC_FULL;

  // dac slices placed at their read bit positions
  wire logic [DW-1:0] boost_word;
  wire logic [DW-1:0] value_word;
  wire logic [DW-1:0] h4_word;
  wire logic [DW-1:0] offset_word;
  wire logic [DW-1:0] neg_word;
  assign boost_word = DW'(dac_boost_i); // [RULE13]
  assign value_word = DW'(dac_value_i); // [RULE11]
  assign h4_word = DW'(dac_4h_i); // [RULE11]
  assign offset_word = DW'(dac_offset_i) << MMS_HI_LSB; // [RULE12]
  assign neg_word = DW'(dac_4neg_i) << MMS_HI_LSB; // [RULE12]

  // read words of the two dac addresses in each access mode
  wire logic [DW-1:0] dac_addr_word;
  wire logic [DW-1:0] comb_addr_word;
  wire logic [DW-1:0] dac_data;
  wire logic dac_none;
  assign dac_addr_word = dm_value ? value_word
    : dm_offset ? offset_word
    : dm_full ? (value_word | offset_word)
    : '0; // [RULE11] [RULE12] [RULE14]
  assign comb_addr_word = dm_value ? h4_word
    : dm_offset ? neg_word
    : dm_full ? (h4_word | neg_word)
    : boost_word; // [RULE13] [RULE14]
  assign dac_data = dac_rd_combined_i ? comb_addr_word : dac_addr_word;
  assign dac_none = !dac_rd_combined_i
    && dm_boost; // [RULE13]

  // decode of the stored read mode
  wire logic rd_low;
  wire logic rd_high;
  wire logic rd_swap;
  assign rd_low = drm_reg == MMS_RD_LOW;
  assign rd_high = drm_reg == MMS_RD_HIGH;
  assign rd_swap = drm_reg == MMS_RD_SWAP;

  // data ram word in each read mode
  wire logic [DW-1:0] ram_lo_word;
  wire logic [DW-1:0] ram_hi_word;
  wire logic [DW-1:0] ram_swap_word;
  wire logic [DW-1:0] ram_fmt;
  assign ram_lo_word = DW'(ram_word_i[MMS_BYTE_W-1:0]); // [RULE18]
  assign ram_hi_word = DW'(ram_word_i[DW-1:MMS_BYTE_W]); // [RULE18]
  assign ram_swap_word = {ram_word_i[MMS_BYTE_W-1:0],
    ram_word_i[DW-1:MMS_BYTE_W]}; // [RULE19]
  assign ram_fmt = rd_low ? ram_lo_word
    : rd_high ? ram_hi_word
    : rd_swap ? ram_swap_word
    : ram_word_i; // [RULE17]

  // registered results
  logic [DW-1:0] xfer_reg;
  logic [DW-1:0] dac_out_reg;
  logic dac_none_reg;
  logic [DW-1:0] load_reg;
  logic load_vld_reg;

  // selected shared register, one cycle behind the selection
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      xfer_reg <= '0;
    end else begin
      xfer_reg <= xfer_next; // [RULE4]
    end
  end

  // dac read data, held until the next read
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dac_out_reg <= '0;
    end else if (dac_rd_i) begin
      dac_out_reg <= dac_data;
    end
  end

  // dac read reached nothing, held until the next read
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dac_none_reg <= 1'b0;
    end else if (dac_rd_i) begin
      dac_none_reg <= dac_none; // [RULE13]
    end
  end

  // loaded word, held until the next load
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      load_reg <= '0;
    end else if (ram_load_i) begin
      load_reg <= ram_fmt; // [RULE20]
    end
  end

  // load strobe, one cycle behind the request
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      load_vld_reg <= 1'b0;
    end else begin
      load_vld_reg <= ram_load_i;
    end
  end

  // mode state outputs
  assign ctrl_upper_o = ctrl_reg;
  assign channel_transfer_sel_o = tgt_reg;
  assign channel_transfer_reg_o = xfer_reg;
  assign converter_mode_field_o = dcc_reg;
  assign dac_access_field_o = dacm_reg;
  assign ram_read_mode_field_o = drm_reg;

  // data result outputs
  assign dac_rd_data_o = dac_out_reg;
  assign dac_rd_none_o = dac_none_reg;
  assign load_data_o = load_reg;
  assign load_valid_o = load_vld_reg;

endmodule // mms_mode_set

`default_nettype wire

// ==== tb/mms_mode_set_props.sv ====
// checker: mode-set decoder properties at the top-level ports
`timescale 1ns/1ps
`default_nettype none
module mms_mode_set_props
  import mms_pkg::*;
#(
  parameter int DW = 16
) (
  input wire logic mclk_i, reset_n_i, instr_valid_i, ram_load_i,
  input wire logic [15:0] instr_i,
  input wire logic [DW-1:0] ram_word_i, load_data_o,
  input wire logic [7:0] ctrl_upper_o,
  input wire logic [1:0] channel_transfer_sel_o, dac_access_field_o,
  input wire logic [1:0] ram_read_mode_field_o,
  input wire logic converter_mode_field_o, load_valid_o
);
  logic crb, crt, dcc, dac, drm;
  logic [1:0] rm;
  // decode of the five mode-set words
  assign crb = instr_valid_i && instr_i[15:5] == MMS_CRB_OPC && !instr_i[3];
  assign crt = instr_valid_i && instr_i[15:2] == MMS_CRT_OPC;
  assign dcc = instr_valid_i && instr_i[15:1] == MMS_DCC_OPC;
  assign dac = instr_valid_i && instr_i[15:2] == MMS_DAC_OPC;
  assign drm = instr_valid_i && instr_i[15:2] == MMS_DRM_OPC;
  assign rm = ram_read_mode_field_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  a_crb_level: assert property (
    crb |=> ctrl_upper_o[$past(instr_i[2:0])] == $past(instr_i[4]))
    else $error("control bit not set to level");
  a_crb_others: assert property (
    crb |=> ((ctrl_upper_o ^ $past(ctrl_upper_o)) &
      ~(8'h01 << $past(instr_i[2:0]))) == 8'h00)
    else $error("unselected control bit changed");
  a_tgt_select: assert property (
    crt |=> channel_transfer_sel_o == $past(instr_i[1:0]))
    else $error("shared target not taken");
  a_conv_select: assert property (
    dcc |=> converter_mode_field_o == $past(instr_i[0]))
    else $error("converter mode not taken");
  a_dac_select: assert property (
    dac |=> dac_access_field_o == $past(instr_i[1:0]))
    else $error("dac mode not taken");
  a_rd_select: assert property (
    drm |=> rm == $past(instr_i[1:0]))
    else $error("read mode not taken");
  a_rd_hold: assert property (!drm |=> $stable(rm))
    else $error("read mode changed without instruction");
  a_load_word: assert property (
    ram_load_i && rm == 2'b00 |=> load_valid_o && load_data_o == $past(ram_word_i))
    else $error("word load wrong");
  a_load_low: assert property (
    ram_load_i && rm == 2'b01 |=> load_data_o == {8'h00, $past(ram_word_i[7:0])})
    else $error("low byte load wrong");
  a_load_swap: assert property (
    ram_load_i && rm == 2'b11 |=>
      load_data_o == {$past(ram_word_i[7:0]), $past(ram_word_i[15:8])})
    else $error("swapped load wrong");
endmodule // mms_mode_set_props
bind mms_mode_set mms_mode_set_props #(.DW(DW)) i_mms_mode_set_props (
  .mclk_i, .reset_n_i, .instr_valid_i, .ram_load_i, .instr_i, .ram_word_i,
  .load_data_o, .ctrl_upper_o, .channel_transfer_sel_o, .dac_access_field_o,
  .ram_read_mode_field_o, .converter_mode_field_o, .load_valid_o);
`default_nettype wire

// ==== tb/mms_src_model.sv ====
// source model: shared transfer registers and dac sources of the cores
`timescale 1ns/1ps
`default_nettype none
module mms_src_model (
  // shared transfer registers of the four cores
  output logic [15:0] xs_o, xu_o, xc_o, xb_o,
  // dac sources
  output logic [7:0] val_o, h4_o, bst_o,
  output logic [5:0] ofs_o,
  output logic [3:0] neg_o
);
  // distinct patterns so a wrong selection always shows
  assign xs_o = 16'h1111;
  assign xu_o = 16'h2222;
  assign xc_o = 16'h3333;
  assign xb_o = 16'h4444;
  assign val_o = 8'h5a;
  assign h4_o = 8'hc3;
  assign bst_o = 8'h7e;
  assign ofs_o = 6'h2d;
  assign neg_o = 4'h9;
endmodule // mms_src_model
`default_nettype wire

// ==== tb/mms_mode_set_tb_top.sv ====
// testbench: mode-set decoder and its mode-driven data paths
`timescale 1ns/1ps
`default_nettype none
module mms_mode_set_tb_top;
  logic mclk_i, reset_n_i, instr_valid_i, dac_rd_i, dac_rd_combined_i;
  logic ram_load_i, converter_mode_field_o, dac_rd_none_o, load_valid_o;
  logic [15:0] instr_i, ram_word_i, channel_transfer_reg_o, dac_rd_data_o;
  logic [15:0] load_data_o, xfer_self_i, xfer_other_uc_i, xfer_other_ch_i;
  logic [15:0] xfer_other_both_i;
  logic [7:0] dac_value_i, dac_4h_i, dac_boost_i, ctrl_upper_o;
  logic [5:0] dac_offset_i;
  logic [3:0] dac_4neg_i;
  logic [1:0] channel_transfer_sel_o, dac_access_field_o, ram_read_mode_field_o;
  int failures = 0, cmp_count = 0, cyc = 0;
  wire logic [15:0] st = {1'b0, ctrl_upper_o, channel_transfer_sel_o,
    converter_mode_field_o, dac_access_field_o, ram_read_mode_field_o};
  // rows: instruction word, then expected packed mode state
  logic [31:0] rows [11] = '{32'h3757_4004, 32'h3750_4084, 32'h3758_4084,
    32'h3747_0084, 32'h358e_00c4, 32'h358f_00e4, 32'h3503_00f4,
    32'h3586_00f8, 32'h3587_00fc, 32'h3581_00fd, 32'h3502_00ed};
  logic [15:0] dexp [8] = '{16'h0000, 16'h007e, 16'h005a, 16'h00c3,
    16'h2d00, 16'h0900, 16'h2d5a, 16'h09c3};
  mms_mode_set i_mms_mode_set (.mclk_i, .reset_n_i, .instr_valid_i, .instr_i,
    .xfer_self_i, .xfer_other_uc_i, .xfer_other_ch_i, .xfer_other_both_i,
    .dac_value_i, .dac_offset_i, .dac_4h_i, .dac_4neg_i, .dac_boost_i,
    .dac_rd_i, .dac_rd_combined_i, .ram_load_i, .ram_word_i, .ctrl_upper_o,
    .channel_transfer_sel_o, .channel_transfer_reg_o, .converter_mode_field_o,
    .dac_access_field_o, .ram_read_mode_field_o, .dac_rd_data_o,
    .dac_rd_none_o, .load_data_o, .load_valid_o);
  mms_src_model i_mms_src_model (.xs_o(xfer_self_i), .xu_o(xfer_other_uc_i),
    .xc_o(xfer_other_ch_i), .xb_o(xfer_other_both_i), .val_o(dac_value_i),
    .h4_o(dac_4h_i), .bst_o(dac_boost_i), .ofs_o(dac_offset_i),
    .neg_o(dac_4neg_i));
  // clock and hang guard
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one instruction strobe, checked at the following falling edge
  task automatic send(input logic [15:0] w);
    @(posedge mclk_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  // one load or dac read strobe
  task automatic pulse(input logic ld, cb, input logic [15:0] w);
    @(posedge mclk_i);
    ram_load_i <= ld;
    dac_rd_i <= !ld;
    dac_rd_combined_i <= cb;
    ram_word_i <= w;
    @(posedge mclk_i);
    ram_load_i <= 1'b0;
    dac_rd_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  initial begin
    logic [15:0] w, e;
    {mclk_i, reset_n_i, instr_valid_i, dac_rd_i} = 4'h0;
    {dac_rd_combined_i, ram_load_i, instr_i, ram_word_i} = 34'h0;
    repeat (10) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("reset state", 16'h0004, st);
    foreach (rows[i]) begin
      send(rows[i][31:16]);
      chk("mode state", rows[i][15:0], st);
    end
    for (int t = 0; t < 4; t++) begin
      send(16'h358c + 16'(t));
      @(negedge mclk_i);
      chk("transfer reg", 16'((t + 1) * 16'h1111), channel_transfer_reg_o);
    end
    for (int m = 0; m < 4; m++) begin
      w = 16'h12ab + 16'(m);
      send(16'h3580 + 16'(m));
      pulse(1'b1, 1'b0, w);
      case (m)
        0: e = w;
        1: e = {8'h00, w[7:0]};
        2: e = {8'h00, w[15:8]};
        default: e = {w[7:0], w[15:8]};
      endcase
      chk("load data", e, load_data_o);
      chk("load valid", 16'h0001, {15'h0, load_valid_o});
    end
    for (int k = 0; k < 8; k++) begin
      send(16'h3584 + 16'(k / 2));
      pulse(1'b0, k[0], 16'h0000);
      chk("dac read", dexp[k], dac_rd_data_o);
      chk("dac none", 16'(k == 0), {15'h0, dac_rd_none_o});
    end
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("reset again", 16'h0004, st);
    results();
  end
endmodule // mms_mode_set_tb_top
`default_nettype wire
